// ==== hw/adc_out_defines.svh ====
// register addresses, field positions, reset values and timing counts
// assumes a 16-bit data word behind an 8-bit address on the serial port
`ifndef ADC_OUT_DEFINES_SVH
`define ADC_OUT_DEFINES_SVH

`define ADDR_SOFT_RESET    8'h00
`define ADDR_CONFIG        8'h01
`define ADDR_PATTERN_SYNC  8'h02
`define ADDR_RAMP_RESET    8'h0a
`define ADDR_RAMP_CTRL     8'h25
`define ADDR_CLOCK_PHASE   8'h42
`define ADDR_LANE_FORMAT   8'h46
`define ADDR_EXT_REF       8'h4a

`define BIT_SOFT_RESET     0
`define BIT_UNLOCK         4
`define BIT_SYNC_ENABLE    13
`define BIT_PIN_SELECT     14
`define BIT_RAMP_ENABLE    6
`define BIT_CM_ENABLE_LO   15
`define BIT_CM_ENABLE_HI   3
`define PHASE_MSB          6
`define PHASE_LSB          5
`define BIT_TWO_LANE       0
`define BIT_TWOS           2
`define BIT_MSB_FIRST      3
`define SEQ_MSB            5
`define SEQ_LSB            4
`define BIT_EXT_REF_ENABLE 0

`define PHASE_RESET        2'h2
`define SRC_REF_PINS       2'h0
`define SRC_COMMON_MODE    2'h3

`define OB_POS_CLAMP       12'hfff
`define OB_NEG_CLAMP       12'h000
`define TC_POS_CLAMP       12'h7ff
`define TC_NEG_CLAMP       12'h800
`define SIGN_FLIP          12'h800
`define SAMPLE_MSB         4'hb

`define WORD_LAST          5'h17
`define SLOT_LAST          4'hb
`define HALF_LAST          4'h5
`define HALF_SLOTS         4'h6
`define QUARTER_LAST       2'h3
`define LATENCY            4'hb

`define PIN_DATA           0
`define PIN_SCLK           1
`define PIN_CSN            2
`define PIN_RSTN           3
`define PIN_ALIGN          4
`define PIN_IDLE           5'h0e

`endif

// ==== hw/adc_out_pkg.sv ====
// types shared by the output formatter, buffer and lane multiplexer
// assumes four channels of 12-bit samples
package adc_out_pkg;
  typedef enum logic [1:0] {SEQ_BYTE, SEQ_BIT, SEQ_WORD} bit_sequence_type;
  typedef logic [11:0] sample_type;
  typedef sample_type [3:0] channel_set_type;
endpackage

// ==== hw/adc_serial_output.sv ====
// output side of a four-channel 12-bit converter: format, latency,
// buffering, lane serialization, bit and frame clocks, serial registers
// assumes samples arrive on sys_clk; serial and strap pins are async
`include "adc_out_defines.svh"

module adc_serial_output (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         resetPinN,
  input  wire logic                         chipSelectN,
  input  wire logic                         serialClock,
  input  wire logic                         serialData,
  input  wire logic                         patternAlignPin,
  input  wire logic                         sampleValid,
  input  wire adc_out_pkg::channel_set_type sampleIn,
  input  wire logic [3:0]                   overloadPos,
  input  wire logic [3:0]                   overloadNeg,
  output logic                              sampleReady,
  output logic                              bitClockOut,
  output logic                              frameClockOut,
  output logic [3:0]                        dataLaneA,
  output logic [3:0]                        dataLaneB,
  output logic                              topReferencePinSelect,
  output logic                              commonModePinSelect,
  output logic                              internalRefPowerDown
);
  import adc_out_pkg::*;

  logic [4:0]       pinMeta;
  logic [4:0]       pinSync;
  logic [4:0]       pinPrev;
  logic [22:0]      shiftReg;
  logic [4:0]       shiftCount;
  logic             softReset;
  logic             syncEnable;
  logic             patternAlignPinSelect;
  logic             upperRegisterUnlock;
  logic             externalReferenceEnable;
  logic             refCommonModeEnableLo;
  logic             refCommonModeEnableHi;
  logic             twosComplementSelect;
  logic             twoLane;
  logic             msbFirst;
  bit_sequence_type bitSeq;
  logic [1:0]       phase;
  logic             rampEnable;
  sample_type       rampResetVal;
  sample_type       ramp [4];
  channel_set_type  pipe [`LATENCY];
  logic [3:0]       pipeFill;
  logic [1:0]       quarter;
  logic [3:0]       slot;
  sample_type       wordA [4];
  sample_type       wordB [4];
  sample_type       wordHold [4];
  channel_set_type  bufOut;
  logic             bufOutValid;
  logic [3:0]       muxA;
  logic [3:0]       muxB;

  function automatic logic hit(logic [7:0] addr, logic [7:0] want);
    hit = addr == want;
  endfunction

  function automatic sample_type formatSample(sample_type raw, logic pos,
                                              logic neg, logic twos);
    if (pos)
      formatSample = twos ? `TC_POS_CLAMP : `OB_POS_CLAMP;
    else if (neg)
      formatSample = twos ? `TC_NEG_CLAMP : `OB_NEG_CLAMP;
    else
      formatSample = twos ? raw ^ `SIGN_FLIP : raw;
  endfunction

  // serial port and strap pins: two flops before anything looks at them
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinMeta <= `PIN_IDLE;
      pinSync <= `PIN_IDLE;
      pinPrev <= `PIN_IDLE;
    end
    else
    begin
      pinMeta <= {patternAlignPin, resetPinN, chipSelectN, serialClock,
                  serialData};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  wire        sclkRise  = pinSync[`PIN_SCLK] && !pinPrev[`PIN_SCLK];
  wire        pinRise   = pinSync[`PIN_ALIGN] && !pinPrev[`PIN_ALIGN];
  wire        csActive  = !pinSync[`PIN_CSN];
  wire        anyReset  = rst || !pinSync[`PIN_RSTN] || softReset;
  wire        wordDone  = csActive && sclkRise && shiftCount == `WORD_LAST;
  wire [23:0] fullWord  = {shiftReg, pinSync[`PIN_DATA]};
  wire [7:0]  wrAddr    = fullWord[23:16];
  wire [15:0] wrData    = fullWord[15:0];

  wire wrSoft   = wordDone && hit(wrAddr, `ADDR_SOFT_RESET);
  wire wrConfig = wordDone && hit(wrAddr, `ADDR_CONFIG);
  wire wrSync   = wordDone && hit(wrAddr, `ADDR_PATTERN_SYNC);
  wire wrRampV  = wordDone && hit(wrAddr, `ADDR_RAMP_RESET);
  wire wrRampC  = wordDone && hit(wrAddr, `ADDR_RAMP_CTRL);
  wire wrPhase  = wordDone && hit(wrAddr, `ADDR_CLOCK_PHASE);
  wire wrLane   = wordDone && hit(wrAddr, `ADDR_LANE_FORMAT);
  wire wrExtRef = wordDone && hit(wrAddr, `ADDR_EXT_REF);

  // bits past a whole number of 24-bit words are dropped when cs rises
  always_ff @(posedge sys_clk)
  begin
    if (rst || !csActive)
      shiftCount <= '0;
    else if (sclkRise)
      shiftCount <= wordDone ? '0 : 5'(shiftCount + 1'b1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sclkRise)
      shiftReg <= fullWord[22:0];
  end

  // software reset clears the registers, then drops by itself
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      softReset <= 1'b0;
    else
      softReset <= wrSoft && wrData[`BIT_SOFT_RESET];
  end

  always_ff @(posedge sys_clk)
  begin
    if (anyReset)
    begin
      syncEnable              <= 1'b0;
      patternAlignPinSelect   <= 1'b0;
      upperRegisterUnlock     <= 1'b0;
      externalReferenceEnable <= 1'b0;
      refCommonModeEnableLo   <= 1'b0;
      refCommonModeEnableHi   <= 1'b0;
      twosComplementSelect    <= 1'b0;
      msbFirst                <= 1'b0;
      twoLane                 <= 1'b0;
      bitSeq                  <= SEQ_BYTE;
      phase                   <= `PHASE_RESET;
      rampEnable              <= 1'b0;
      rampResetVal            <= '0;
    end
    else
    begin
      if (wrConfig)
        upperRegisterUnlock <= wrData[`BIT_UNLOCK];
      if (wrSync)
      begin
        syncEnable            <= wrData[`BIT_SYNC_ENABLE];
        patternAlignPinSelect <= wrData[`BIT_PIN_SELECT];
      end
      if (wrRampV)
        rampResetVal <= wrData[11:0];
      if (wrRampC)
        rampEnable <= wrData[`BIT_RAMP_ENABLE];
      if (wrPhase)
      begin
        refCommonModeEnableLo <= wrData[`BIT_CM_ENABLE_LO];
        refCommonModeEnableHi <= wrData[`BIT_CM_ENABLE_HI];
        phase                 <= wrData[`PHASE_MSB:`PHASE_LSB];
      end
      if (wrLane)
      begin
        twoLane              <= wrData[`BIT_TWO_LANE];
        twosComplementSelect <= wrData[`BIT_TWOS];
        msbFirst             <= wrData[`BIT_MSB_FIRST];
        bitSeq <= bit_sequence_type'(wrData[`SEQ_MSB:`SEQ_LSB]);
      end
      if (wrExtRef)
        externalReferenceEnable <= wrData[`BIT_EXT_REF_ENABLE];
    end
  end

  // a write of the enable bit without pin select aligns at once; the
  // pin only counts once both bits are set
  wire swSyncPulse = wrSync && wrData[`BIT_SYNC_ENABLE] &&
                     !wrData[`BIT_PIN_SELECT];
  wire pinGate     = syncEnable && patternAlignPinSelect;
  wire syncFire    = swSyncPulse || (pinRise && pinGate);
  wire strobe      = sampleValid && sampleReady;
  wire primed      = pipeFill == `LATENCY;

  channel_set_type formatted;
  channel_set_type rampSet;
  channel_set_type bufIn;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_chan
      assign formatted[ch] = formatSample(sampleIn[ch], overloadPos[ch],
                                          overloadNeg[ch],
                                          twosComplementSelect);
      assign rampSet[ch] = ramp[ch];

      always_ff @(posedge sys_clk)
      begin
        if (anyReset)
          ramp[ch] <= '0;
        else if (syncFire)
          ramp[ch] <= rampResetVal;
        else if (strobe)
          ramp[ch] <= 12'(ramp[ch] + 1'b1);
      end

      lane_mux u_mux (
        .twoLane  (twoLane),
        .msbFirst (msbFirst),
        .bitSeq   (bitSeq),
        .slot     (slot),
        .wordA    (wordA[ch]),
        .wordB    (wordB[ch]),
        .wordHold (wordHold[ch]),
        .laneA    (muxA[ch]),
        .laneB    (muxB[ch])
      );
    end
  endgenerate

  assign bufIn = rampEnable ? rampSet : pipe[`LATENCY - 1'b1];

  // converter latency: a sample leaves after eleven more sample strobes
  always_ff @(posedge sys_clk)
  begin
    if (strobe)
    begin
      pipe[0] <= formatted;
      for (int i = 1; i < `LATENCY; i++)
        pipe[i] <= pipe[i - 1];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (anyReset)
      pipeFill <= '0;
    else if (strobe && !primed)
      pipeFill <= 4'(pipeFill + 1'b1);
  end

  // bit slot timing: four sys_clk quarters per slot, twelve per frame
  wire endFrame = slot == `SLOT_LAST && quarter == `QUARTER_LAST;
  wire midFrame = slot == `HALF_LAST && quarter == `QUARTER_LAST;
  wire take     = endFrame || (midFrame && twoLane);

  pair_buffer #(
    .WIDTH ($bits(channel_set_type)),
    .DEPTH (2)
  ) u_buf (
    .sys_clk  (sys_clk),
    .rst      (anyReset),
    .inValid  (strobe && primed),
    .inData   (bufIn),
    .inReady  (sampleReady),
    .outValid (bufOutValid),
    .outData  (bufOut),
    .outReady (take)
  );

  always_ff @(posedge sys_clk)
  begin
    if (anyReset)
    begin
      quarter <= '0;
      slot    <= '0;
    end
    else
    begin
      quarter <= 2'(quarter + 1'b1);
      if (quarter == `QUARTER_LAST)
        slot <= (slot == `SLOT_LAST) ? '0 : 4'(slot + 1'b1);
    end
  end

  // an empty buffer at a take point sends a zero word, keeping clocks
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_word
      always_ff @(posedge sys_clk)
      begin
        if (anyReset)
        begin
          wordA[ch]    <= '0;
          wordB[ch]    <= '0;
          wordHold[ch] <= '0;
        end
        else
        begin
          if (endFrame)
          begin
            wordA[ch]    <= bufOutValid ? bufOut[ch] : '0;
            wordHold[ch] <= wordB[ch];
          end
          if (midFrame && twoLane)
            wordB[ch] <= bufOutValid ? bufOut[ch] : '0;
        end
      end
    end
  endgenerate

  wire extRefOn = upperRegisterUnlock && externalReferenceEnable;
  wire [1:0] referenceSourceSelect = {refCommonModeEnableHi,
                                      refCommonModeEnableLo};

  // bit clock, frame clock and data lanes all lag the slot counters by one clock alike
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bitClockOut           <= 1'b0;
      frameClockOut         <= 1'b0;
      dataLaneA             <= '0;
      dataLaneB             <= '0;
      topReferencePinSelect <= 1'b0;
      commonModePinSelect   <= 1'b0;
      internalRefPowerDown  <= 1'b0;
    end
    else
    begin
      bitClockOut   <= slot[0] ^ (quarter >= phase);
      frameClockOut <= slot <= `HALF_LAST;
      dataLaneA     <= muxA;
      dataLaneB     <= muxB;
      topReferencePinSelect <= extRefOn &&
        referenceSourceSelect == `SRC_REF_PINS;
      commonModePinSelect <= extRefOn &&
        referenceSourceSelect == `SRC_COMMON_MODE;
      internalRefPowerDown <= extRefOn &&
        (referenceSourceSelect == `SRC_REF_PINS ||
         referenceSourceSelect == `SRC_COMMON_MODE);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_frame_start;
    slot == '0 && quarter == '0 && !anyReset;
  endsequence

  sequence s_high_half;
    frameClockOut [*8];
  endsequence

  a_pin_gated_off: assert property (
    (pinRise && !pinGate && !swSyncPulse && !strobe && !anyReset)
      |=> $stable(ramp[0]))
    else $error("alignment pin acted while not selected");

  a_select_cleared: assert property (
    anyReset |=> !patternAlignPinSelect)
    else $error("pin select survived a reset");

  a_sync_aligns: assert property (
    (syncFire && !anyReset) |=>
      (ramp[0] == rampResetVal && ramp[3] == rampResetVal))
    else $error("ramps not aligned after sync");

  a_twos_format: assert property (
    (strobe && !overloadPos[0] && !overloadNeg[0]) |=>
      pipe[0][0] == ($past(twosComplementSelect) ?
                     $past(sampleIn[0]) ^ `SIGN_FLIP : $past(sampleIn[0])))
    else $error("sample encoding wrong");

  a_pos_clamp: assert property (
    (strobe && overloadPos[1]) |=>
      pipe[0][1] == ($past(twosComplementSelect) ? `TC_POS_CLAMP
                                                 : `OB_POS_CLAMP))
    else $error("positive overload code wrong");

  a_neg_clamp: assert property (
    (strobe && overloadNeg[2] && !overloadPos[2]) |=>
      pipe[0][2] == ($past(twosComplementSelect) ? `TC_NEG_CLAMP
                                                 : `OB_NEG_CLAMP))
    else $error("negative overload code wrong");

  a_frame_high: assert property (
    s_frame_start |=> s_high_half)
    else $error("frame clock not high at frame start");

  a_phase_edge: assert property (
    (quarter == phase && phase != '0 && phase == $past(phase) &&
     !anyReset) |=>
      $changed(bitClockOut))
    else $error("bit clock edge not at programmed phase");

  a_one_lane_take: assert property (
    (endFrame && bufOutValid && !anyReset) |=> wordA[0] == $past(bufOut[0]))
    else $error("frame word not loaded at frame end");

  a_two_lane_mid: assert property (
    (midFrame && twoLane && bufOutValid && !anyReset) |=>
      wordB[1] == $past(bufOut[1]))
    else $error("second word not loaded at half frame");
endmodule

// ==== hw/lane_mux.sv ====
// picks the bit on each lane of one channel for the current bit slot
// assumes slot runs 0..11, wordA and wordHold stand still within a frame and wordB within each half
`include "adc_out_defines.svh"

module lane_mux (
  input  wire logic                          twoLane,
  input  wire logic                          msbFirst,
  input  wire adc_out_pkg::bit_sequence_type bitSeq,
  input  wire logic [3:0]                    slot,
  input  wire adc_out_pkg::sample_type       wordA,
  input  wire adc_out_pkg::sample_type       wordB,
  input  wire adc_out_pkg::sample_type       wordHold,
  output logic                               laneA,
  output logic                               laneB
);
  import adc_out_pkg::*;

  function automatic logic pick12(sample_type w, logic [3:0] s,
                                  logic msb);
    pick12 = msb ? w[4'(`SAMPLE_MSB - s)] : w[s];
  endfunction

  function automatic logic pick6(logic [5:0] g, logic [2:0] k,
                                 logic msb);
    pick6 = msb ? g[3'(3'h5 - k)] : g[k];
  endfunction

  function automatic logic [5:0] everyOther(sample_type w, logic odd);
    logic [5:0] g;
    g = '0;
    for (int i = 0; i < 6; i++)
      g[i] = w[2 * i + int'(odd)];
    everyOther = g;
  endfunction

  wire             secondHalf = slot > `HALF_LAST;
  wire [2:0]       halfSlot   = secondHalf ? 3'(slot - `HALF_SLOTS)
                                           : slot[2:0];
  wire sample_type half       = secondHalf ? wordB : wordA;

  always_comb
  begin
    laneA = pick12(wordA, slot, msbFirst);
    laneB = 1'b0;
    if (twoLane)
    begin
      unique case (bitSeq)
        SEQ_BYTE:
        begin
          laneA = pick6(half[11:6], halfSlot, msbFirst);
          laneB = pick6(half[5:0], halfSlot, msbFirst);
        end
        SEQ_BIT:
        begin
          laneA = pick6(everyOther(half, 1'b1), halfSlot, msbFirst);
          laneB = pick6(everyOther(half, 1'b0), halfSlot, msbFirst);
        end
        SEQ_WORD:
        begin
          laneA = pick12(wordA, slot, msbFirst);
          laneB = pick12(wordHold, slot, msbFirst);
        end
        default:
        begin
          laneA = 1'b0;
          laneB = 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== hw/pair_buffer.sv ====
// small valid/ready buffer between the sample pipeline and serializer
// assumes both sides run on sys_clk; inReady comes from a flip-flop
module pair_buffer #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [CW-1:0]    count;

  function automatic logic [AW-1:0] advance(logic [AW-1:0] p);
    advance = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  wire          push       = inValid && inReady;
  wire          pop        = outValid && outReady;
  wire [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));

  assign outValid = count != '0;
  assign outData  = store[rdPtr];

  always_ff @(posedge sys_clk)
  begin
    if (push)
      store[wrPtr] <= inData;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      count   <= '0;
      inReady <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= advance(wrPtr);
      if (pop)
        rdPtr <= advance(rdPtr);
      count   <= next_count;
      inReady <= next_count < CW'(DEPTH);
    end
  end

  a_buffer_full: assert property (@(posedge sys_clk) disable iff (rst)
    (count == CW'(DEPTH)) |-> !inReady)
    else $error("buffer accepts data while full");
endmodule

// ==== verif/adc_serial_output_test.sv ====
// bench: serial register writes, constant samples, lane word checks
// assumes the receiver model is wired to the lanes and clocks
module adc_serial_output_test;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_out_pkg::*;
  logic            sys_clk = 1'h0;
  logic            rst = 1'h1;
  logic            chipSelectN = 1'h1;
  logic            serialClock = 1'h0;
  logic            serialData = 1'h0;
  logic            sampleValid = 1'h0;
  logic            patternAlignPin = 1'h0;
  channel_set_type sampleIn = '0;
  logic [3:0]      overloadPos = 4'h0;
  logic [3:0]      overloadNeg = 4'h0;
  wire logic       sampleReady, bitClockOut, frameClockOut;
  wire logic       topSel, cmSel, refPd;
  wire logic [3:0] laneA, laneB, clkPat;
  wire logic [15:0] frames;
  channel_set_type rxA, rxB;
  int              mismatches = 0;
  int              n_checks = 0;

  adc_serial_output DUT (.sys_clk(sys_clk), .rst(rst), .resetPinN(1'h1),
    .chipSelectN(chipSelectN), .serialClock(serialClock),
    .serialData(serialData), .patternAlignPin(patternAlignPin),
    .sampleValid(sampleValid), .sampleIn(sampleIn),
    .overloadPos(overloadPos), .overloadNeg(overloadNeg),
    .sampleReady(sampleReady), .bitClockOut(bitClockOut),
    .frameClockOut(frameClockOut), .dataLaneA(laneA), .dataLaneB(laneB),
    .topReferencePinSelect(topSel), .commonModePinSelect(cmSel),
    .internalRefPowerDown(refPd));
  lane_receiver rx (.sys_clk(sys_clk), .frameClockOut(frameClockOut),
    .bitClockOut(bitClockOut), .dataLaneA(laneA), .dataLaneB(laneB),
    .rxA(rxA), .rxB(rxB), .clkPat(clkPat), .frames(frames));

  always #25 sys_clk = ~sys_clk;
  // one strobe per 24 clocks: too fast for one-lane, so the buffer refuses
  always
  begin
    repeat (23) @(posedge sys_clk);
    sampleValid <= 1'h1;
    @(posedge sys_clk);
    sampleValid <= 1'h0;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    n_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, want);
    end
  endtask

  // 24 bits msb first, 400 ns serial clock period
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] w;
    w = {a, d};
    @(posedge sys_clk) chipSelectN <= 1'h0;
    for (int i = 23; i >= 0; i--)
    begin
      serialData <= w[i];
      repeat (4) @(posedge sys_clk);
      serialClock <= 1'h1;
      repeat (4) @(posedge sys_clk);
      serialClock <= 1'h0;
    end
    repeat (4) @(posedge sys_clk);
    chipSelectN <= 1'h1;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic frames_wait(input int n);
    logic [15:0] f;
    int k;
    f = frames;
    k = 0;
    while (int'(frames - f) < n && k < 60 * n)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 60 * n)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: no frames", $time);
      close_out();
    end
  endtask

  // long wait lets the pipeline and buffer flush the old setting
  task automatic run(input logic [7:0] a, input logic [15:0] fmt,
                     input logic [11:0] s, input logic p, input logic n,
                     input logic [11:0] expA, input logic [11:0] expB);
    wr(a, fmt);
    sampleIn <= {4{s}};
    overloadPos <= {4{p}};
    overloadNeg <= {4{n}};
    frames_wait(20);
    for (int i = 0; i < 4; i++)
    begin
      check(rxA[i], expA);
      check(rxB[i], expB);
    end
    $display("test done: format %h sample %h", fmt, s);
  endtask

  // ramp on, reloads to 800, msb first: bit 11 shows whether a sync hit
  task automatic ramp_setup;
    wr(8'h25, 16'h0040);
    wr(8'h0a, 16'h0800);
    wr(8'h46, 16'h0008);
  endtask

  task automatic align(input logic pulse, input logic want);
    patternAlignPin <= pulse;
    repeat (8) @(posedge sys_clk);
    patternAlignPin <= 1'h0;
    frames_wait(6);
    for (int i = 0; i < 4; i++)
      check({11'h0, rxA[i][11]}, {11'h0, want});
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (2) @(posedge sys_clk);
    check({11'h0, sampleReady}, 12'h1);
    // unmapped address leaves reset format: lsb first, offset binary
    run(8'h7f, 16'h0000, 12'h5a3, 1'h0, 1'h0, 12'hc5a, 12'h0);
    run(8'h46, 16'h000c, 12'h5a3, 1'h0, 1'h0, 12'hda3, 12'h0);
    run(8'h46, 16'h000c, 12'h5a3, 1'h1, 1'h0, 12'h7ff, 12'h0);
    run(8'h46, 16'h000c, 12'h5a3, 1'h0, 1'h1, 12'h800, 12'h0);
    run(8'h46, 16'h0008, 12'h5a3, 1'h1, 1'h0, 12'hfff, 12'h0);
    run(8'h46, 16'h0008, 12'h5a3, 1'h0, 1'h1, 12'h000, 12'h0);
    run(8'h46, 16'h0009, 12'h5a3, 1'h0, 1'h0, 12'h596, 12'h8e3);
    run(8'h46, 16'h0019, 12'h5a3, 1'h0, 1'h0, 12'h34d, 12'hc71);
    run(8'h46, 16'h0029, 12'h5a3, 1'h0, 1'h0, 12'h5a3, 12'h5a3);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h42, 16'(p << 5));
      frames_wait(2);
      check({8'h0, clkPat}, {8'h0, 4'hf << p});
    end
    $display("test done: bit clock phase");
    wr(8'h4a, 16'h0001);
    check({11'h0, topSel}, 12'h0);
    wr(8'h01, 16'h0010);
    check({10'h0, topSel, refPd}, 12'h3);
    wr(8'h42, 16'h8048);
    check({10'h0, cmSel, topSel}, 12'h2);
    $display("test done: reference select");
    wr(8'h00, 16'h0001);
    run(8'h7f, 16'h0000, 12'h5a3, 1'h0, 1'h0, 12'hc5a, 12'h0);
    ramp_setup();
    align(1'h1, 1'h0);
    wr(8'h02, 16'h6000);
    align(1'h0, 1'h0);
    align(1'h1, 1'h1);
    wr(8'h00, 16'h0001);
    ramp_setup();
    align(1'h1, 1'h0);
    wr(8'h02, 16'h2000);
    align(1'h0, 1'h1);
    $display("test done: pattern alignment");
    close_out();
  end
endmodule

// ==== verif/lane_receiver.sv ====
// receiver model: finds words from the frame clock, captures lanes raw
// assumes outputs change on sys_clk and each bit stands four cycles
module lane_receiver
  import adc_out_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            frameClockOut,
  input  wire logic            bitClockOut,
  input  wire logic [3:0]      dataLaneA,
  input  wire logic [3:0]      dataLaneB,
  output channel_set_type      rxA,
  output channel_set_type      rxB,
  output logic [3:0]           clkPat,
  output logic [15:0]          frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic            framePrev = 1'h0;
  logic [15:0]     count = 16'h0;
  logic [5:0]      phaseCount = 6'h0;
  channel_set_type shA;
  channel_set_type shB;
  wire logic       rise = frameClockOut && !framePrev;
  wire logic [5:0] c = rise ? 6'h0 : phaseCount;
  assign frames = count;
  // sample mid-slot, first bit lands in bit 11 of the word
  always @(posedge sys_clk)
  begin
    framePrev <= frameClockOut;
    phaseCount <= c + 6'h1;
    if (c < 6'h4)
      clkPat[c[1:0]] <= bitClockOut;
    if (c[1:0] == 2'h2)
      for (int i = 0; i < 4; i++)
      begin
        shA[i] <= {shA[i][10:0], dataLaneA[i]};
        shB[i] <= {shB[i][10:0], dataLaneB[i]};
      end
    if (c == 6'h2f)
    begin
      rxA <= shA;
      rxB <= shB;
      count <= count + 16'h1;
    end
  end
endmodule
